// *** hw/dtcr_pkg.sv ***
package dtcr_pkg;

  // Special-function addresses of the timer data, control and mode registers
  localparam logic [7:0] ADDR_TIMER_CONTROL  = 8'h88;
  localparam logic [7:0] ADDR_TIMER_MODE     = 8'h89;
  localparam logic [7:0] ADDR_TIMER0_LOW     = 8'h8a;
  localparam logic [7:0] ADDR_TIMER1_LOW     = 8'h8b;
  localparam logic [7:0] ADDR_TIMER0_HIGH    = 8'h8c;
  localparam logic [7:0] ADDR_TIMER1_HIGH    = 8'h8d;

  // Reset values
  localparam logic [7:0] DATA_RESET          = 8'h00;
  localparam logic [1:0] MODE_RESET          = 2'h0;

  // Control register field positions
  localparam int unsigned CTL_T1_FLAG_BIT    = 7;
  localparam int unsigned CTL_T1_RUN_BIT     = 6;
  localparam int unsigned CTL_T0_FLAG_BIT    = 5;
  localparam int unsigned CTL_T0_RUN_BIT     = 4;

  // Mode register field positions (low bit of each two-bit mode field)
  localparam int unsigned MOD_T1_LSB         = 4;
  localparam int unsigned MOD_T0_LSB         = 0;

  // Width of the prescaled low part in the 13-bit mode
  localparam int unsigned PRESCALE_BITS      = 5;
  localparam logic [4:0]  PRESCALE_MAX       = 5'h1f;
  localparam logic [7:0]  BYTE_MAX           = 8'hff;

  // Operating modes of one counter
  typedef enum logic [1:0] {
    DTCR_MODE_13BIT  = 2'h0,
    DTCR_MODE_16BIT  = 2'h1,
    DTCR_MODE_RELOAD = 2'h2,
    DTCR_MODE_SPLIT  = 2'h3
  } dtcr_mode_t;

endpackage : dtcr_pkg

// *** hw/dtcr_count_step.sv ***
// Next-state arithmetic of one timer/counter byte pair
module dtcr_count_step
  import dtcr_pkg::*;
(
  input  wire logic [1:0] mode_i,
  input  wire logic       run_low_i,
  input  wire logic       run_high_i,
  input  wire logic [7:0] low_i,
  input  wire logic [7:0] high_i,
  output logic      [7:0] low_nxt_o,
  output logic      [7:0] high_nxt_o,
  output logic            ovf_low_o,
  output logic            ovf_high_o
);

  wire logic       low_full  = (low_i == BYTE_MAX);
  wire logic       high_full = (high_i == BYTE_MAX);
  wire logic       pre_full  = (low_i[PRESCALE_BITS-1:0] == PRESCALE_MAX);
  wire logic [7:0] low_inc   = low_i + 8'h01;
  wire logic [7:0] high_inc  = high_i + 8'h01;
  wire logic [4:0] pre_inc   = low_i[PRESCALE_BITS-1:0] + 5'h01;

  // Counting per mode; a halted counter keeps its value
  always_comb begin
    low_nxt_o  = low_i;
    high_nxt_o = high_i;
    ovf_low_o  = 1'b0;
    ovf_high_o = 1'b0;
    case (dtcr_mode_t'(mode_i))
      DTCR_MODE_13BIT: begin
        if (run_low_i) begin                                // [RULE5] [RULE6]
          low_nxt_o = {low_i[7:PRESCALE_BITS], pre_inc};
          if (pre_full) begin
            high_nxt_o = high_inc;
            ovf_low_o  = high_full;
          end
        end
      end
      DTCR_MODE_16BIT: begin
        if (run_low_i) begin                                // [RULE5] [RULE6]
          low_nxt_o = low_inc;
          if (low_full) begin
            high_nxt_o = high_inc;
            ovf_low_o  = high_full;
          end
        end
      end
      DTCR_MODE_RELOAD: begin
        if (run_low_i) begin                                // [RULE3] [RULE6]
          low_nxt_o = low_full ? high_i : low_inc;          // [RULE9]
          ovf_low_o = low_full;
        end
      end
      DTCR_MODE_SPLIT: begin
        if (run_low_i) begin                                // [RULE8]
          low_nxt_o = low_inc;
          ovf_low_o = low_full;
        end
        if (run_high_i) begin                               // [RULE8]
          high_nxt_o = high_inc;
          ovf_high_o = high_full;
        end
      end
      default: begin
        low_nxt_o = low_i;
      end
    endcase
  end

endmodule : dtcr_count_step

// *** hw/dtcr_top.sv ***
// What this block does
// RULE1 - Counter 0 is seen by software as a low-byte and a high-byte register.
// RULE2 - Counter 1 is seen by software as a low-byte and a high-byte register.
// RULE3 - In auto-reload mode only the low byte counts, eight bits wide, and the high byte holds the reload value.
// RULE4 - All four data registers clear to zero on power-on and timer reset, and software may read and write them at any time.
// RULE5 - A two-bit mode field picks 13-bit, 16-bit, 8-bit auto-reload or split operation for each counter; split on counter 1 only holds it.
// RULE6 - A counter advances only while its run-control bit is one and holds otherwise.
// RULE7 - Overflow sets the counter's flag, and entry to the matching service routine clears it.
// RULE8 - In split mode counter 0's low byte runs under counter 0's controls, its high byte under counter 1's, and counter 1 is held.
// RULE9 - On auto-reload overflow the low byte is loaded from the high byte, which stays unchanged.
module dtcr_top
  import dtcr_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       timer_rst_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       sfr_rd_i,
  input  wire logic       timer0_isr_enter_i,
  input  wire logic       timer1_isr_enter_i,
  output logic      [7:0] sfr_rdata_o,
  output logic            timer0_overflow_flag_o,
  output logic            timer1_overflow_flag_o
);

  // Stored state
  logic [7:0] timer0_count_low_r;
  logic [7:0] timer0_count_high_r;
  logic [7:0] timer1_count_low_r;
  logic [7:0] timer1_count_high_r;
  logic       timer0_run_control_r;
  logic       timer1_run_control_r;
  logic       timer0_overflow_flag_r;
  logic       timer1_overflow_flag_r;
  logic [1:0] timer0_mode_r;
  logic [1:0] timer1_mode_r;
  logic [7:0] rdata_r;

  // Next values
  logic [7:0] t0_low_nxt;
  logic [7:0] t0_high_nxt;
  logic [7:0] t1_low_nxt;
  logic [7:0] t1_high_nxt;
  logic       t0_ovf_low;
  logic       t0_ovf_high;
  logic       t1_ovf_low;

  // Either reset source clears all counter, control and mode state; read data clears on system reset only
  wire logic clear_all = sys_rst_i | timer_rst_i;                        // [RULE4]

  // Write strobes per register
  wire logic wr_ctl     = sfr_wr_i & (sfr_addr_i == ADDR_TIMER_CONTROL);
  wire logic wr_mode    = sfr_wr_i & (sfr_addr_i == ADDR_TIMER_MODE);
  wire logic wr_t0_low  = sfr_wr_i & (sfr_addr_i == ADDR_TIMER0_LOW);   // [RULE1]
  wire logic wr_t0_high = sfr_wr_i & (sfr_addr_i == ADDR_TIMER0_HIGH);  // [RULE1]
  wire logic wr_t1_low  = sfr_wr_i & (sfr_addr_i == ADDR_TIMER1_LOW);   // [RULE2]
  wire logic wr_t1_high = sfr_wr_i & (sfr_addr_i == ADDR_TIMER1_HIGH);  // [RULE2]

  // Split mode of counter 0 borrows counter 1's run bit and stops counter 1
  wire logic t0_split   = (timer0_mode_r == DTCR_MODE_SPLIT);
  wire logic t1_split   = (timer1_mode_r == DTCR_MODE_SPLIT);
  wire logic t1_hold    = t0_split | t1_split;                            // [RULE8]
  wire logic t1_run     = timer1_run_control_r & ~t1_hold;                // [RULE6] [RULE8]

  // Counter 0 arithmetic; its high byte follows counter 1's run bit in split mode
  dtcr_count_step u_step0 (
    .mode_i     (timer0_mode_r),
    .run_low_i  (timer0_run_control_r),
    .run_high_i (timer1_run_control_r),
    .low_i      (timer0_count_low_r),
    .high_i     (timer0_count_high_r),
    .low_nxt_o  (t0_low_nxt),
    .high_nxt_o (t0_high_nxt),
    .ovf_low_o  (t0_ovf_low),
    .ovf_high_o (t0_ovf_high)
  );

  // Counter 1 arithmetic; its split branch never counts since it is held then
  dtcr_count_step u_step1 (
    .mode_i     (timer1_mode_r),
    .run_low_i  (t1_run),
    .run_high_i (1'b0),
    .low_i      (timer1_count_low_r),
    .high_i     (timer1_count_high_r),
    .low_nxt_o  (t1_low_nxt),
    .high_nxt_o (t1_high_nxt),
    .ovf_low_o  (t1_ovf_low),
    .ovf_high_o ()
  );

  // Flag events: counter 1's flag is driven by counter 0's high byte in split mode
  wire logic t0_flag_set = t0_ovf_low;                                   // [RULE7]
  wire logic t1_flag_set = t0_split ? t0_ovf_high : t1_ovf_low;          // [RULE7] [RULE8]

  // Software write or service entry clears; a same-cycle overflow still wins
  wire logic t0_flag_keep = wr_ctl ? sfr_wdata_i[CTL_T0_FLAG_BIT]
                                   : (timer0_overflow_flag_r & ~timer0_isr_enter_i);
  wire logic t1_flag_keep = wr_ctl ? sfr_wdata_i[CTL_T1_FLAG_BIT]
                                   : (timer1_overflow_flag_r & ~timer1_isr_enter_i);
  wire logic t0_flag_nxt  = t0_flag_set | t0_flag_keep;                  // [RULE7]
  wire logic t1_flag_nxt  = t1_flag_set | t1_flag_keep;                  // [RULE7]

  // Data bytes: a software write replaces that byte's count this cycle
  wire logic [7:0] t0_low_sel  = wr_t0_low  ? sfr_wdata_i : t0_low_nxt;   // [RULE4]
  wire logic [7:0] t0_high_sel = wr_t0_high ? sfr_wdata_i : t0_high_nxt;  // [RULE4]
  wire logic [7:0] t1_low_sel  = wr_t1_low  ? sfr_wdata_i : t1_low_nxt;   // [RULE4]
  wire logic [7:0] t1_high_sel = wr_t1_high ? sfr_wdata_i : t1_high_nxt;  // [RULE4]

  // Read-back views of control and mode; unimplemented bits read zero
  wire logic [7:0] ctl_view  = {timer1_overflow_flag_r, timer1_run_control_r,
                                timer0_overflow_flag_r, timer0_run_control_r, 4'h0};
  wire logic [7:0] mode_view = {2'h0, timer1_mode_r, 2'h0, timer0_mode_r};

  // Read address decode per register
  wire logic rd_ctl     = (sfr_addr_i == ADDR_TIMER_CONTROL);
  wire logic rd_mode    = (sfr_addr_i == ADDR_TIMER_MODE);
  wire logic rd_t0_low  = (sfr_addr_i == ADDR_TIMER0_LOW);
  wire logic rd_t0_high = (sfr_addr_i == ADDR_TIMER0_HIGH);
  wire logic rd_t1_low  = (sfr_addr_i == ADDR_TIMER1_LOW);
  wire logic rd_t1_high = (sfr_addr_i == ADDR_TIMER1_HIGH);

  // Read data select; unmapped addresses return zero
  wire logic [7:0] rdata_nxt =
      rd_ctl     ? ctl_view            :
      rd_mode    ? mode_view           :
      rd_t0_low  ? timer0_count_low_r  :  // [RULE1]
      rd_t0_high ? timer0_count_high_r :  // [RULE1]
      rd_t1_low  ? timer1_count_low_r  :  // [RULE2]
      rd_t1_high ? timer1_count_high_r :  // [RULE2]
      DATA_RESET;

  // Counter 0 low byte
  always_ff @(posedge sys_clk_i) begin
    if (clear_all) begin                                                 // [RULE4]
      timer0_count_low_r <= DATA_RESET;
    end else begin
      timer0_count_low_r <= t0_low_sel;
    end
  end

  // Counter 0 high byte
  always_ff @(posedge sys_clk_i) begin
    if (clear_all) begin                                                 // [RULE4]
      timer0_count_high_r <= DATA_RESET;
    end else begin
      timer0_count_high_r <= t0_high_sel;
    end
  end

  // Counter 1 low byte
  always_ff @(posedge sys_clk_i) begin
    if (clear_all) begin                                                 // [RULE4]
      timer1_count_low_r <= DATA_RESET;
    end else begin
      timer1_count_low_r <= t1_low_sel;
    end
  end

  // Counter 1 high byte
  always_ff @(posedge sys_clk_i) begin
    if (clear_all) begin                                                 // [RULE4]
      timer1_count_high_r <= DATA_RESET;
    end else begin
      timer1_count_high_r <= t1_high_sel;
    end
  end

  // Run control bits, changed only by a control write
  always_ff @(posedge sys_clk_i) begin
    if (clear_all) begin
      timer0_run_control_r <= 1'b0;
      timer1_run_control_r <= 1'b0;
    end else if (wr_ctl) begin                                           // [RULE6]
      timer0_run_control_r <= sfr_wdata_i[CTL_T0_RUN_BIT];
      timer1_run_control_r <= sfr_wdata_i[CTL_T1_RUN_BIT];
    end
  end

  // Overflow flags
  always_ff @(posedge sys_clk_i) begin
    if (clear_all) begin
      timer0_overflow_flag_r <= 1'b0;
      timer1_overflow_flag_r <= 1'b0;
    end else begin
      timer0_overflow_flag_r <= t0_flag_nxt;
      timer1_overflow_flag_r <= t1_flag_nxt;
    end
  end

  // Counter 0 mode field
  always_ff @(posedge sys_clk_i) begin
    if (clear_all) begin
      timer0_mode_r <= MODE_RESET;
    end else if (wr_mode) begin                                          // [RULE5]
      timer0_mode_r <= sfr_wdata_i[MOD_T0_LSB +: 2];
    end
  end

  // Counter 1 mode field
  always_ff @(posedge sys_clk_i) begin
    if (clear_all) begin
      timer1_mode_r <= MODE_RESET;
    end else if (wr_mode) begin                                          // [RULE5]
      timer1_mode_r <= sfr_wdata_i[MOD_T1_LSB +: 2];
    end
  end

  // Registered read data, updated on each read strobe
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rdata_r <= DATA_RESET;
    end else if (sfr_rd_i) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign sfr_rdata_o            = rdata_r;
  assign timer0_overflow_flag_o = timer0_overflow_flag_r;
  assign timer1_overflow_flag_o = timer1_overflow_flag_r;

endmodule : dtcr_top

// *** verif/dtcr_checker.sv ***
// Port-level checks of the timer data block
module dtcr_checker
  import dtcr_pkg::*;
(
  input wire logic       sys_clk_i,
  input wire logic       sys_rst_i,
  input wire logic       timer_rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic       sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic       sfr_rd_i,
  input wire logic       timer0_isr_enter_i,
  input wire logic       timer1_isr_enter_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic       timer0_overflow_flag_o,
  input wire logic       timer1_overflow_flag_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] run_r;
  // Address decode
  wire logic wr_ctl = sfr_wr_i && sfr_addr_i == ADDR_TIMER_CONTROL;
  wire logic data_a = sfr_addr_i inside {[ADDR_TIMER0_LOW:ADDR_TIMER1_HIGH]};
  wire logic mapped = sfr_addr_i inside {[ADDR_TIMER_CONTROL:ADDR_TIMER1_HIGH]};
  // Mirror of the two run bits as software wrote them
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || timer_rst_i) run_r <= 2'h0;
    else if (wr_ctl) run_r <= {sfr_wdata_i[CTL_T1_RUN_BIT], sfr_wdata_i[CTL_T0_RUN_BIT]};
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  AST_RST_CLEAR: assert property ($fell(sys_rst_i) |-> sfr_rdata_o == DATA_RESET
    && !timer0_overflow_flag_o && !timer1_overflow_flag_o) else $error("reset not cleared");
  AST_UNMAPPED: assert property (sfr_rd_i && !sfr_wr_i && !mapped |=>
    sfr_rdata_o == DATA_RESET) else $error("unmapped read not zero");
  AST_READBACK: assert property ((sfr_wr_i && data_a && run_r == 2'h0 && !timer_rst_i)
    ##1 (!sfr_wr_i && !sfr_rd_i && !timer_rst_i && $stable(sfr_addr_i))
    ##1 (sfr_rd_i && !sfr_wr_i && !timer_rst_i && $stable(sfr_addr_i))
    |=> sfr_rdata_o == $past(sfr_wdata_i, 3)) else $error("readback mismatch");
  AST_HOLD0: assert property (!run_r[0] && !wr_ctl |=> !$rose(timer0_overflow_flag_o))
    else $error("flag 0 rose while halted");
  AST_HOLD1: assert property (!run_r[1] && !wr_ctl |=> !$rose(timer1_overflow_flag_o))
    else $error("flag 1 rose while halted");
  AST_ISR0: assert property (timer0_isr_enter_i && !run_r[0] && !wr_ctl |=>
    !timer0_overflow_flag_o) else $error("flag 0 not cleared");
  AST_ISR1: assert property (timer1_isr_enter_i && !run_r[1] && !wr_ctl |=>
    !timer1_overflow_flag_o) else $error("flag 1 not cleared");
  AST_STAY0: assert property (timer0_overflow_flag_o && !timer0_isr_enter_i && !wr_ctl
    && !timer_rst_i |=> timer0_overflow_flag_o) else $error("flag 0 dropped");
endmodule : dtcr_checker

// *** verif/dtcr_cpu_model.sv ***
// Processor side of the special-function bus
module dtcr_cpu_model (
  input  wire logic       sys_clk_i,
  input  wire logic [7:0] sfr_rdata_i,
  output logic      [7:0] sfr_addr_o,
  output logic            sfr_wr_o,
  output logic      [7:0] sfr_wdata_o,
  output logic            sfr_rd_o,
  output logic      [2:0] strobe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bus idle at time zero
  initial begin
    sfr_addr_o = 8'h00;
    sfr_wr_o = 1'b0;
    sfr_wdata_o = 8'h00;
    sfr_rd_o = 1'b0;
    strobe_o = 3'h0;
  end
  // One-cycle write and one idle edge, so a strobe never drops and rises at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_o = a;
    sfr_wdata_o = d;
    sfr_wr_o = 1'b1;
    @(negedge sys_clk_i);
    sfr_wr_o = 1'b0;
    @(negedge sys_clk_i);
  endtask : wr
  // One-cycle read and one idle edge; data is settled by the next falling edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfr_addr_o = a;
    sfr_rd_o = 1'b1;
    @(negedge sys_clk_i);
    sfr_rd_o = 1'b0;
    d = sfr_rdata_i;
    @(negedge sys_clk_i);
  endtask : rd
  // Pulse of timer reset and service-routine entries
  task automatic strobe(input logic [2:0] m);
    strobe_o = m;
    @(negedge sys_clk_i);
    strobe_o = 3'h0;
  endtask : strobe
endmodule : dtcr_cpu_model

// *** verif/tb_top.sv ***
module tb_top
  import dtcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o;
  logic sfr_wr_i, sfr_rd_i, timer0_overflow_flag_o, timer1_overflow_flag_o;
  logic [2:0] strb;
  int num_errors = 0;
  int comparisons = 0;
  always #4 sys_clk_i = ~sys_clk_i;
  dtcr_cpu_model cpu (.sys_clk_i(sys_clk_i), .sfr_rdata_i(sfr_rdata_o), .sfr_addr_o(sfr_addr_i),
    .sfr_wr_o(sfr_wr_i), .sfr_wdata_o(sfr_wdata_i), .sfr_rd_o(sfr_rd_i), .strobe_o(strb));
  dtcr_top dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .timer_rst_i(strb[2]),
    .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rd_i(sfr_rd_i), .timer0_isr_enter_i(strb[0]), .timer1_isr_enter_i(strb[1]),
    .sfr_rdata_o(sfr_rdata_o), .timer0_overflow_flag_o(timer0_overflow_flag_o),
    .timer1_overflow_flag_o(timer1_overflow_flag_o));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    cpu.rd(a, d);
    chk($sformatf("reg %h", a), e, d);
  endtask : rchk
  // Load both counters, run n edges, compare flags and all four bytes
  task automatic run_case(input logic [7:0] md, l0, h0, l1, h1, ctl, input int n,
                          input logic [7:0] el0, eh0, el1, eh1, input logic [1:0] ef);
    cpu.strobe(3'h4);
    cpu.wr(ADDR_TIMER_MODE, md);
    cpu.wr(ADDR_TIMER0_LOW, l0);
    cpu.wr(ADDR_TIMER0_HIGH, h0);
    cpu.wr(ADDR_TIMER1_LOW, l1);
    cpu.wr(ADDR_TIMER1_HIGH, h1);
    cpu.wr(ADDR_TIMER_CONTROL, ctl);
    repeat (n - 2) @(negedge sys_clk_i);
    chk("flags", {6'h0, ef}, {6'h0, timer1_overflow_flag_o, timer0_overflow_flag_o});
    cpu.wr(ADDR_TIMER_CONTROL, {ef[1], 1'b0, ef[0], 5'h00});
    cpu.strobe(3'h3);
    chk("cleared flags", 8'h00, {6'h0, timer1_overflow_flag_o, timer0_overflow_flag_o});
    rchk(ADDR_TIMER0_LOW, el0);
    rchk(ADDR_TIMER0_HIGH, eh0);
    rchk(ADDR_TIMER1_LOW, el1);
    rchk(ADDR_TIMER1_HIGH, eh1);
  endtask : run_case
  task automatic final_report;
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  // Main sequence
  initial begin
    repeat (20) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    for (int a = 8'h88; a <= 8'h8e; a++) rchk(8'(a), 8'h00);
    for (int a = 8'h8a; a <= 8'h8e; a++) begin
      cpu.wr(8'(a), 8'h5a ^ 8'(a));
      rchk(8'(a), (a == 8'h8e) ? 8'h00 : 8'h5a ^ 8'(a));
    end
    run_case(8'h02, 8'hfe, 8'hf0, 8'h00, 8'h00, 8'h10, 5, 8'hf3, 8'hf0, 8'h00, 8'h00, 2'h1);
    run_case(8'h10, 8'h00, 8'h00, 8'hfe, 8'hff, 8'h40, 3, 8'h00, 8'h00, 8'h01, 8'h00, 2'h2);
    run_case(8'h00, 8'h3e, 8'hff, 8'h00, 8'h00, 8'h10, 3, 8'h21, 8'h00, 8'h00, 8'h00, 2'h1);
    run_case(8'h03, 8'hff, 8'hfe, 8'h11, 8'h22, 8'h50, 3, 8'h02, 8'h01, 8'h11, 8'h22, 2'h3);
    cpu.strobe(3'h4);
    for (int a = 8'h8a; a <= 8'h8d; a++) rchk(8'(a), 8'h00);
    final_report();
  end
  // Watchdog against a hang
  initial begin
    #100000;
    num_errors++;
    final_report();
  end
endmodule : tb_top
bind dtcr_top dtcr_checker checker_i (.sys_clk_i, .sys_rst_i, .timer_rst_i, .sfr_addr_i,
  .sfr_wr_i, .sfr_wdata_i, .sfr_rd_i, .timer0_isr_enter_i, .timer1_isr_enter_i,
  .sfr_rdata_o, .timer0_overflow_flag_o, .timer1_overflow_flag_o);
